//--- cfo_ctrl.sv
`default_nettype none
module cfo_ctrl
   import cfo_pkg::*;
#(
   parameter int NOUT = cfo_pkg::NUM_OUT
) (
   input  wire logic             clk_sys_in,
   input  wire logic             resetn_in,
   input  wire logic             ref_clk_in,
   input  wire logic [NOUT-1:0]  out_enable_n_in,
   input  wire logic [NOUT-1:0]  reg_enable_in,
   input  wire logic             reg_enable_we_in,
   input  wire logic             power_good_shutdown_pin_in,
   input  wire logic             frequency_select_strap_in,
   input  wire logic [1:0]       serial_address_strap_in,
   input  wire logic [1:0]       loop_mode_strap_in,
   output logic      [NOUT-1:0]  diff_output_true_out,
   output logic      [NOUT-1:0]  diff_output_complement_out,
   output logic      [NOUT-1:0]  diff_output_oe_n_out,
   output logic      [NOUT-1:0]  reg_enable_out,
   output cfo_strap_s            strap_out,
   output logic                  straps_valid_out,
   output logic                  locked_out,
   output logic                  shutdown_out
);
   import cfo_pkg::*;

   typedef enum logic [1:0] {
      CFO_WAIT_PG,
      CFO_WAIT_LOCK,
      CFO_RUN,
      CFO_DOWN
   } cfo_state_e;

   cfo_state_e        state_r;
   logic [NOUT-1:0]   oe_n_s;
   logic [1:0]        misc_s;
   logic              ref_s;
   logic              pg_s;
   logic              ref_d_r;
   logic              ref_rise;
   logic              ref_fall;
   logic [7:0]        ref_idle_r;
   logic              ref_alive;
   logic [4:0]        lock_cnt_r;
   logic              pg_seen_r;
   logic [1:0]        pd_cnt_r;
   logic              pd_armed_r;
   logic [NOUT-1:0]   gate_r;
   logic [NOUT-1:0]   tri_r;
   logic [NOUT-1:0]   want;
   cfo_loop_e         loop_dec;

   cfo_sync #(.WIDTH(NOUT), .INIT({NOUT{1'b1}})) u_oe_sync (
      .clk_sys_in (clk_sys_in),
      .resetn_in  (resetn_in),
      .async_in   (out_enable_n_in),
      .level_out  (oe_n_s)
   );

   cfo_sync #(.WIDTH(2), .INIT(2'h0)) u_misc_sync (
      .clk_sys_in (clk_sys_in),
      .resetn_in  (resetn_in),
      .async_in   ({ref_clk_in, power_good_shutdown_pin_in}),
      .level_out  (misc_s)
   );

   assign ref_s = misc_s[1];
   assign pg_s  = misc_s[0];

   // reference edge tracking; the output follows the reference edge-for-edge
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         ref_d_r <= 1'b0;
      end else begin
         ref_d_r <= ref_s;
      end
   end
   assign ref_rise = ref_s & ~ref_d_r;
   assign ref_fall = ~ref_s & ref_d_r;

   // activity detector
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         ref_idle_r <= 8'h00;
      end else if (ref_rise || ref_fall) begin
         ref_idle_r <= 8'h00;
      end else if (ref_idle_r != 8'(REF_TIMEOUT_CY)) begin
         ref_idle_r <= ref_idle_r + 8'h01;
      end
   end
   assign ref_alive = (ref_idle_r != 8'(REF_TIMEOUT_CY));

   // three-level decode
   always_comb begin
      unique case (loop_mode_strap_in)
         TRI_LOW:  loop_dec = CFO_LOOP_LOW_BW;
         TRI_MID:  loop_dec = CFO_LOOP_BYPASS;
         TRI_HIGH: loop_dec = CFO_LOOP_HIGH_BW;
         default:  loop_dec = CFO_LOOP_BYPASS;
      endcase
   end

   // straps caught once at first power-good rise
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         pg_seen_r        <= 1'b0;
         straps_valid_out <= 1'b0;
         strap_out        <= '0;
      end else if (!pg_seen_r && pg_s) begin
         pg_seen_r                <= 1'b1;
         straps_valid_out         <= 1'b1;
         strap_out.freq_100m      <= frequency_select_strap_in;
         strap_out.serial_addr    <= serial_address_strap_in;
         strap_out.loop_mode      <= loop_dec;
      end
   end

   // software enable bits
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         reg_enable_out <= OE_REG_RESET[NOUT-1:0];
      end else if (reg_enable_we_in) begin
         reg_enable_out <= reg_enable_in;
      end
   end

   // shutdown qualifier: count complement rises (true falls) with request low
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in || !pg_seen_r || pg_s) begin
         pd_cnt_r   <= 2'h0;
         pd_armed_r <= 1'b0;
      end else if (ref_fall) begin
         if (pd_cnt_r != 2'(PD_RISE_EDGES)) begin
            pd_cnt_r <= pd_cnt_r + 2'h1;
         end
         if (pd_cnt_r == 2'(PD_RISE_EDGES - 1)) begin
            pd_armed_r <= 1'b1;
         end
      end
   end

   // power state
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         state_r    <= CFO_WAIT_PG;
         lock_cnt_r <= 5'h00;
      end else begin
         unique case (state_r)
            CFO_WAIT_PG: begin
               lock_cnt_r <= 5'h00;
               if (pg_s && ref_alive) begin
                  state_r <= CFO_WAIT_LOCK;
               end
            end
            CFO_WAIT_LOCK: begin
               if (!pg_s || !ref_alive) begin
                  state_r    <= CFO_WAIT_PG;
               end else if (lock_cnt_r == 5'(LOCK_EDGES)) begin
                  state_r <= CFO_RUN;
               end else if (ref_rise) begin
                  lock_cnt_r <= lock_cnt_r + 5'h01;
               end
            end
            CFO_RUN: begin
               // complement falls when true rises
               if ((pd_armed_r && ref_rise) || !ref_alive) begin
                  state_r <= CFO_DOWN;
               end
            end
            CFO_DOWN: begin
               lock_cnt_r <= 5'h00;
               if (pg_s && ref_alive) begin
                  state_r <= CFO_WAIT_LOCK;
               end
            end
         endcase
      end
   end

   assign want = ~oe_n_s & reg_enable_out;

   // gating opens only at a reference rise, in step with ref_d_r, and clears whenever state_r leaves CFO_RUN: whole phases on both lines unless ref is lost
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         gate_r <= '0;
      end else if (state_r != CFO_RUN) begin
         gate_r <= '0;
      end else if (ref_rise) begin
         gate_r <= pd_armed_r ? '0 : want;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         diff_output_true_out       <= '0;
         diff_output_complement_out <= '0;
         diff_output_oe_n_out       <= '1;
         tri_r                      <= '1;
         locked_out                 <= 1'b0;
         shutdown_out               <= 1'b0;
      end else begin
         tri_r        <= (state_r == CFO_RUN) ? '0 : '1;
         locked_out   <= (state_r == CFO_RUN);
         shutdown_out <= (state_r == CFO_DOWN);
         for (int i = 0; i < NOUT; i++) begin
            // one output per reference edge: no divider, no offset
            diff_output_true_out[i]       <= gate_r[i] & ref_d_r;
            diff_output_complement_out[i] <= gate_r[i] & ~ref_d_r;
            diff_output_oe_n_out[i]       <= tri_r[i];
         end
      end
   end
endmodule : cfo_ctrl
`default_nettype wire

//--- cfo_pkg.sv
`default_nettype none
package cfo_pkg;
   localparam int          NUM_OUT        = 8;
   localparam logic [7:0]  OE_REG_RESET   = 8'hFF;
   localparam int          SYNC_STAGES    = 3;
   // frequency strap: high = 100 MHz, low = 133.33 MHz
   localparam logic        FSEL_100M      = 1'h1;
   // shutdown is honoured after this many complement-line rising edges with request low
   localparam int          PD_RISE_EDGES  = 2;
   // reference activity window: ref must toggle within this many nanoseconds
   localparam real         REF_TIMEOUT_NS = 200.0;
   localparam real         CLK_PERIOD_NS  = 8.0;
   localparam int          REF_TIMEOUT_CY = int'(REF_TIMEOUT_NS / CLK_PERIOD_NS);
   // lock settles after this many reference rising edges
   localparam int          LOCK_EDGES     = 16;
   // three-level loop mode strap encoding (two comparator bits)
   localparam logic [1:0]  TRI_LOW        = 2'h0;
   localparam logic [1:0]  TRI_MID        = 2'h1;
   localparam logic [1:0]  TRI_HIGH       = 2'h3;

   typedef enum logic [1:0] {
      CFO_LOOP_LOW_BW,
      CFO_LOOP_BYPASS,
      CFO_LOOP_HIGH_BW
   } cfo_loop_e;

   typedef struct packed {
      logic       freq_100m;
      logic [1:0] serial_addr;
      cfo_loop_e  loop_mode;
   } cfo_strap_s;

   typedef struct packed {
      logic [7:0] true_line;
      logic [7:0] comp_line;
      logic [7:0] drive_en_n;
   } cfo_diff_s;
endpackage : cfo_pkg
`default_nettype wire

//--- cfo_sync.sv
`default_nettype none
module cfo_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input  wire logic             clk_sys_in,
   input  wire logic             resetn_in,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] level_out
);
   import cfo_pkg::*;
   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;

   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         s1_r      <= INIT;
         s2_r      <= INIT;
         s3_r      <= INIT;
         level_out <= INIT;
      end else begin
         s1_r <= async_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         // a bit changes only once the second and third stages agree
         for (int i = 0; i < WIDTH; i++) begin
            if (s2_r[i] == s3_r[i]) begin
               level_out[i] <= s3_r[i];
            end
         end
      end
   end
endmodule : cfo_sync
`default_nettype wire

//--- cfo_ctrl_props.sv
`default_nettype none
module cfo_ctrl_props
   import cfo_pkg::*;
#(
   parameter int NOUT = 8
) (
   input wire logic            clk_sys_in,
   input wire logic            resetn_in,
   input wire logic [NOUT-1:0] reg_enable_in,
   input wire logic            reg_enable_we_in,
   input wire logic            power_good_shutdown_pin_in,
   input wire logic [NOUT-1:0] diff_output_true_out,
   input wire logic [NOUT-1:0] diff_output_complement_out,
   input wire logic [NOUT-1:0] diff_output_oe_n_out,
   input wire logic [NOUT-1:0] reg_enable_out,
   input wire cfo_strap_s      strap_out,
   input wire logic            straps_valid_out,
   input wire logic            shutdown_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!resetn_in);
   sequence s_pd_req;
      $fell(power_good_shutdown_pin_in) && straps_valid_out && !shutdown_out;
   endsequence
   sequence s_down;
      shutdown_out [*3];
   endsequence
   property p_rst; $rose(resetn_in) |-> reg_enable_out == '1 && diff_output_oe_n_out == '1; endproperty
   property p_wr; reg_enable_we_in |=> reg_enable_out == $past(reg_enable_in); endproperty
   property p_pair; (diff_output_true_out & diff_output_complement_out) == '0; endproperty
   property p_strap; straps_valid_out && $past(straps_valid_out) |-> $stable(strap_out); endproperty
   property p_pd_wait; s_pd_req |-> !shutdown_out [*8]; endproperty
   property p_pd_done; s_pd_req |-> ##[1:150] shutdown_out; endproperty
   property p_off;
      s_down |-> diff_output_oe_n_out == '1 && (diff_output_true_out | diff_output_complement_out) == '0;
   endproperty
   property p_run_hi;
      $rose(diff_output_true_out[0]) |=> diff_output_true_out[0] [*3];
   endproperty
   property p_comp_whole;
      $fell(diff_output_complement_out[0]) |-> $past(diff_output_complement_out[0], 4);
   endproperty
   a_rst: assert property (p_rst) else $error("enables not at reset value");
   a_wr: assert property (p_wr) else $error("enable write lost");
   a_pair: assert property (p_pair) else $error("true and complement both high");
   a_strap: assert property (p_strap) else $error("straps changed after latch");
   a_pd_wait: assert property (p_pd_wait) else $error("shutdown too early");
   a_pd_done: assert property (p_pd_done) else $error("shutdown too late");
   a_off: assert property (p_off) else $error("outputs not off in shutdown");
   a_run_hi: assert property (p_run_hi) else $error("runt high pulse");
   a_comp_whole: assert property (p_comp_whole) else $error("runt complement pulse");
endmodule : cfo_ctrl_props
bind cfo_ctrl cfo_ctrl_props #(.NOUT(NOUT)) i_props (.clk_sys_in, .resetn_in, .reg_enable_in, .reg_enable_we_in,
   .power_good_shutdown_pin_in, .diff_output_true_out, .diff_output_complement_out, .diff_output_oe_n_out,
   .reg_enable_out, .strap_out, .straps_valid_out, .shutdown_out);
`default_nettype wire

//--- cfo_ref_model.sv
`default_nettype none
module cfo_ref_model #(
   parameter realtime HALF_NS = 64.0
) (
   input  wire logic run_in,
   output wire logic ref_clk_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_r = 1'b0;
   // parks low while stopped
   always begin
      #(HALF_NS) ref_r = run_in ? ~ref_r : 1'b0;
   end
   assign ref_clk_out = ref_r;
endmodule : cfo_ref_model
`default_nettype wire

//--- cfo_ctrl_tb.sv
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; $display("wrong value %0t %h %h", $time, a, b); end end
`define WT(c) begin for (int k = 0; k < 600 && (c) !== 1'b1; k++) @(posedge clk_sys_in); if ((c) !== 1'b1) failures++; end
module cfo_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import cfo_pkg::*;
   // en_n, reg bits, outputs expected to toggle
   localparam logic [23:0] ROWS [8] = '{24'h00FFFF, 24'hFFFF00, 24'h000000, 24'h0FF0F0,
                                       24'h55FFAA, 24'h00A5A5, 24'h3CC3C3, 24'h7E8181};
   localparam cfo_loop_e MODES [4] = '{CFO_LOOP_LOW_BW, CFO_LOOP_BYPASS, CFO_LOOP_BYPASS, CFO_LOOP_HIGH_BW};
   logic       clk_sys_in = 1'b0, resetn_in = 1'b0, ref_run = 1'b1, power_good_shutdown_pin_in = 1'b0;
   logic       frequency_select_strap_in = 1'b0, reg_enable_we_in = 1'b0;
   logic [1:0] serial_address_strap_in = 2'h0, loop_mode_strap_in = 2'h0;
   logic [7:0] out_enable_n_in = 8'h00, reg_enable_in = 8'hFF;
   logic [7:0] diff_output_true_out, diff_output_complement_out, diff_output_oe_n_out, reg_enable_out;
   logic [7:0] seen_true, seen_comp;
   logic       ref_clk_in, straps_valid_out, locked_out, shutdown_out;
   cfo_strap_s strap_out, exp_strap;
   int         failures = 0, n_compared = 0;
   realtime    t0;
   always #4 clk_sys_in = ~clk_sys_in;
   cfo_ref_model #(.HALF_NS(64.0)) i_ref (.run_in(ref_run), .ref_clk_out(ref_clk_in));
   cfo_ctrl #(.NOUT(8)) i_dut (.clk_sys_in, .resetn_in, .ref_clk_in, .out_enable_n_in, .reg_enable_in,
      .reg_enable_we_in, .power_good_shutdown_pin_in, .frequency_select_strap_in, .serial_address_strap_in,
      .loop_mode_strap_in, .diff_output_true_out, .diff_output_complement_out, .diff_output_oe_n_out,
      .reg_enable_out, .strap_out, .straps_valid_out, .locked_out, .shutdown_out);
   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : print_verdict
   task automatic rst;
      power_good_shutdown_pin_in <= 1'b0;
      resetn_in <= 1'b0;
      repeat (16) @(posedge clk_sys_in);
      resetn_in <= 1'b1;
      @(posedge clk_sys_in);
   endtask : rst
   initial begin
      for (int i = 0; i < 4; i++) begin
         rst();
         `CHK(reg_enable_out, 8'hFF)
         `CHK(diff_output_oe_n_out, 8'hFF)
         `CHK(straps_valid_out, 1'b0)
         exp_strap = '{i[0], ~i[1:0], MODES[i]};
         frequency_select_strap_in <= i[0];
         serial_address_strap_in <= ~i[1:0];
         loop_mode_strap_in <= i[1:0];
         @(posedge clk_sys_in);
         power_good_shutdown_pin_in <= 1'b1;
         `WT(locked_out)
         `CHK(strap_out, exp_strap)
         `CHK(straps_valid_out, 1'b1)
         frequency_select_strap_in <= ~i[0];
         loop_mode_strap_in <= ~i[1:0];
         repeat (20) @(posedge clk_sys_in);
         `CHK(strap_out, exp_strap)
      end
      $display("test straps done");
      foreach (ROWS[r]) begin
         out_enable_n_in <= ROWS[r][23:16];
         reg_enable_in <= ROWS[r][15:8];
         reg_enable_we_in <= 1'b1;
         @(posedge clk_sys_in);
         reg_enable_we_in <= 1'b0;
         repeat (40) @(posedge clk_sys_in);
         seen_true = 8'h00;
         seen_comp = 8'h00;
         repeat (32) begin
            @(posedge clk_sys_in);
            seen_true |= diff_output_true_out;
            seen_comp |= diff_output_complement_out;
         end
         `CHK(reg_enable_out, ROWS[r][15:8])
         `CHK(diff_output_oe_n_out, 8'h00)
         `CHK(seen_true, ROWS[r][7:0])
         `CHK(seen_comp, ROWS[r][7:0])
      end
      @(posedge diff_output_true_out[0]);
      t0 = $realtime;
      @(posedge diff_output_true_out[0]);
      `CHK(int'($realtime - t0), 128)
      $display("test enables done");
      power_good_shutdown_pin_in <= 1'b0;
      `WT(shutdown_out)
      repeat (3) @(posedge clk_sys_in);
      `CHK(diff_output_oe_n_out, 8'hFF)
      `CHK(shutdown_out, 1'b1)
      `CHK(locked_out, 1'b0)
      power_good_shutdown_pin_in <= 1'b1;
      `WT(locked_out & ~shutdown_out)
      repeat (10) @(posedge clk_sys_in);
      `CHK(diff_output_oe_n_out, 8'h00)
      ref_run <= 1'b0;
      repeat (60) @(posedge clk_sys_in);
      `CHK(diff_output_oe_n_out, 8'hFF)
      ref_run <= 1'b1;
      `WT(locked_out & ~shutdown_out)
      repeat (10) @(posedge clk_sys_in);
      `CHK(diff_output_oe_n_out, 8'h00)
      power_good_shutdown_pin_in <= 1'b0;
      `WT(shutdown_out)
      ref_run <= 1'b0;
      repeat (20) @(posedge clk_sys_in);
      `CHK(diff_output_oe_n_out, 8'hFF)
      $display("test power done");
      print_verdict();
   end
   initial begin
      #100us;
      failures++;
      print_verdict();
   end
endmodule : cfo_ctrl_tb
`default_nettype wire
